// *** core/mbg_consts.vh ***
// mbg_consts.vh - constants for the request checker and exception framer
// assumes: included by bare name from core/ design files
`ifndef MBG_CONSTS_VH
`define MBG_CONSTS_VH

// ----------------------------------------------------------------------
// exception codes
// ----------------------------------------------------------------------
`define MBG_EXC_NONE 8'h00
`define MBG_EXC_ILL_FUNC 8'h01
`define MBG_EXC_ILL_ADDR 8'h02
`define MBG_EXC_ILL_VALUE 8'h03
`define MBG_EXC_DEV_FAIL 8'h04
`define MBG_EXC_ACK 8'h05
`define MBG_EXC_BUSY 8'h06
`define MBG_EXC_NAK 8'h07
`define MBG_EXC_PARITY 8'h08
`define MBG_EXC_GW_PATH 8'h0A
`define MBG_EXC_GW_TARGET 8'h0B

// ----------------------------------------------------------------------
// frame fields
// ----------------------------------------------------------------------
`define MBG_EXC_FLAG 8'h80
`define MBG_SLAVE_MIN 8'h01
`define MBG_SLAVE_MAX 8'hF7
`define MBG_FRAME_BYTES 3'h5
`define MBG_POS_SLAVE 3'h0
`define MBG_POS_FUNC 3'h1
`define MBG_POS_CODE 3'h2
`define MBG_POS_CRC_LO 3'h3
`define MBG_POS_CRC_HI 3'h4
`define MBG_CRC_INIT 16'hFFFF
`define MBG_CRC_POLY 16'hA001

// ----------------------------------------------------------------------
// profiles and factory passwords
// ----------------------------------------------------------------------
`define MBG_NUM_PROFILES 4
`define MBG_PW_ADMIN 32'h30303030
`define MBG_PW_SERVICES 32'h31313131
`define MBG_PW_ENGINEER 32'h32323232
`define MBG_PW_OPERATOR 32'h33333333

`endif

// *** core/mbg_crc16.v ***
// mbg_crc16.v - byte-wide crc16 update, reflected polynomial
// assumes: one byte folded per clock when enabled, same clock as caller
`timescale 1ns/1ns
`default_nettype none
`include "mbg_consts.vh"

module mbg_crc16 (
    input wire clock,
    input wire rst,
    input wire init,
    input wire enable,
    input wire [7:0] data,
    output wire [15:0] crc
);

    reg [15:0] crc_reg;
    reg [15:0] crc_next;
    integer i;

    // ------------------------------------------------------------------
    // eight shift steps per byte
    // ------------------------------------------------------------------
    always @* begin
        crc_next = crc_reg ^ {8'h00, data};
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_next[0])
                crc_next = (crc_next >> 1) ^ `MBG_CRC_POLY;
            else
                crc_next = crc_next >> 1;
        end
    end

    // state register
    always @(posedge clock) begin
        if (rst || init)
            crc_reg <= `MBG_CRC_INIT;
        else if (enable)
            crc_reg <= crc_next;
    end

    assign crc = crc_reg;

endmodule // mbg_crc16

`default_nettype wire

// *** core/mbg_guard.v ***
// mbg_guard.v - slave-side request checker and exception frame builder
// assumes: a decoded request arrives as one strobe with its fields and
// check flags from the frame receiver; bytes go out through a byte
// handshake to the line transmitter, which adds timing and silence.
//
// exception frame, one byte per handshake:
//   byte 0  slave number of the request
//   byte 1  request function with the top bit set
//   byte 2  exception code
//   byte 3  crc16 low byte
//   byte 4  crc16 high byte
// protection refusals leave as a one-cycle pulse on cmd_refused with a
// code on cmd_error that stands until the next refusal.
// the hardware lock comes from a pad, so it passes two flip-flops;
// a change of the lock needs two clocks before requests see it.
`timescale 1ns/1ns
`default_nettype none
`include "mbg_consts.vh"

module mbg_guard #(
    parameter NUM_PROFILES = `MBG_NUM_PROFILES
) (
    input wire clock,
    input wire rst,
    // request from the frame receiver
    input wire req_valid,
    input wire [7:0] req_slave,
    input wire [7:0] req_func,
    input wire req_comm_error,
    input wire req_func_ok,
    input wire req_state_ok,
    input wire req_addr_ok,
    input wire req_value_ok,
    input wire req_dev_fail,
    input wire req_long,
    input wire req_prog_fail,
    input wire req_parity_err,
    input wire req_gw_path,
    input wire req_gw_target,
    input wire req_intrusive,
    input wire req_write,
    input wire req_struct_ok,
    input wire [NUM_PROFILES-1:0] req_profile_mask,
    input wire [31:0] req_password,
    // protection and password store
    input wire write_lock,
    input wire pw_load,
    input wire [1:0] pw_index,
    input wire [31:0] pw_value,
    input wire busy_in,
    // outcome towards the application
    output reg normal_go,
    output reg cmd_refused,
    output reg [7:0] cmd_error,
    // exception frame byte stream
    output reg tx_valid,
    output reg [7:0] tx_data,
    output reg tx_last,
    input wire tx_ready
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SEND = 3'b010;
    localparam [2:0] ST_CRC = 3'b100;

    // refusal codes reported on cmd_error
    localparam [7:0] REF_PASSWORD = 8'h01;
    localparam [7:0] REF_LOCK = 8'h02;
    localparam [7:0] REF_STRUCT = 8'h03;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] slave_reg;
    reg [7:0] func_reg;
    reg [7:0] code_reg;
    reg [2:0] idx_reg;
    // password match per profile
    wire [NUM_PROFILES-1:0] pw_match;
    wire pw_ok;
    // decoded outcome of the request now offered
    reg [7:0] exc_code;
    reg [7:0] refuse_code;
    reg [7:0] byte_sel;
    // hardware lock after the two synchroniser flops
    reg lock_meta_reg;
    reg lock_sync_reg;
    wire [15:0] crc;
    wire crc_step;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // factory password of one profile, four repeated digit characters
    function [31:0] default_pw;
        input integer index;
        begin
            case (index)
                0: default_pw = `MBG_PW_ADMIN;
                1: default_pw = `MBG_PW_SERVICES;
                2: default_pw = `MBG_PW_ENGINEER;
                default: default_pw = `MBG_PW_OPERATOR;
            endcase
        end
    endfunction

    // crc low byte once the code byte is folded in
    // used for the byte after the code, before the crc module folds it
    function [7:0] crc_next_lo;
        input [15:0] c;
        input [7:0] d;
        reg [15:0] t;
        integer j;
        begin
            t = c ^ {8'h00, d};
            for (j = 0; j < 8; j = j + 1)
                t = t[0] ? ((t >> 1) ^ `MBG_CRC_POLY) : (t >> 1);
            crc_next_lo = t[7:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // hardware lock synchroniser, the pad is not on this clock
    // ------------------------------------------------------------------
    // only the second flop is read; the first may go metastable
    always @(posedge clock) begin
        if (rst) begin
            lock_meta_reg <= 1'b0;
            lock_sync_reg <= 1'b0;
        end else begin
            lock_meta_reg <= write_lock;
            lock_sync_reg <= lock_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // password store, one word per profile, factory defaults on reset
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_PROFILES; g = g + 1) begin : gen_pw
            reg [31:0] word_reg;
            always @(posedge clock) begin
                if (rst)
                    word_reg <= default_pw(g);
                else if (pw_load && pw_index == g)
                    word_reg <= pw_value;
            end
            // profile assigned to the command and password equal
            assign pw_match[g] = req_profile_mask[g] && (word_reg == req_password);
        end
    endgenerate

    // any assigned profile with a matching password opens the command
    assign pw_ok = |pw_match;

    // ------------------------------------------------------------------
    // exception code selection, first match wins
    // ------------------------------------------------------------------
    // gateway faults lead: the far target cannot answer at all
    // busy comes next, so the master only has to repeat later
    // then the request fields in frame order, then execution faults
    always @* begin
        exc_code = `MBG_EXC_NONE;
        if (req_gw_target)
            exc_code = `MBG_EXC_GW_TARGET;
        else if (req_gw_path)
            exc_code = `MBG_EXC_GW_PATH;
        else if (busy_in)
            exc_code = `MBG_EXC_BUSY;
        else if (!req_func_ok || !req_state_ok)
            exc_code = `MBG_EXC_ILL_FUNC;
        else if (!req_addr_ok)
            exc_code = `MBG_EXC_ILL_ADDR;
        else if (!req_value_ok)
            exc_code = `MBG_EXC_ILL_VALUE;
        else if (req_parity_err)
            exc_code = `MBG_EXC_PARITY;
        else if (req_dev_fail)
            exc_code = `MBG_EXC_DEV_FAIL;
        else if (req_prog_fail)
            exc_code = `MBG_EXC_NAK;
        else if (req_long)
            exc_code = `MBG_EXC_ACK;
    end

    // ------------------------------------------------------------------
    // request intake and protection decision
    // ------------------------------------------------------------------
    // a request is taken only when intact, for a legal slave number and
    // while no frame is on its way out; anything else leaves no trace
    wire slave_ok = (req_slave >= `MBG_SLAVE_MIN) && (req_slave <= `MBG_SLAVE_MAX);
    wire take = req_valid && !req_comm_error && slave_ok && (state_reg == ST_IDLE);
    wire locked = req_write && req_intrusive && lock_sync_reg;
    wire soft_bad = req_intrusive && (!req_struct_ok || !pw_ok);
    wire exc_hit = (exc_code != `MBG_EXC_NONE);

    // refusal code: hardware lock first, then structure, then password
    always @* begin
        refuse_code = `MBG_EXC_NONE;
        if (locked)
            refuse_code = REF_LOCK;
        else if (!req_struct_ok)
            refuse_code = REF_STRUCT;
        else if (!pw_ok)
            refuse_code = REF_PASSWORD;
    end

    always @(posedge clock) begin
        if (rst) begin
            normal_go <= 1'b0;
            cmd_refused <= 1'b0;
            cmd_error <= 8'h00;
            slave_reg <= 8'h00;
            func_reg <= 8'h00;
            code_reg <= 8'h00;
        end else begin
            normal_go <= 1'b0;
            cmd_refused <= 1'b0;
            if (take) begin
                slave_reg <= req_slave;
                func_reg <= req_func | `MBG_EXC_FLAG;
                code_reg <= exc_code;
                if (!exc_hit) begin
                    if (locked || soft_bad) begin
                        cmd_refused <= 1'b1;
                        cmd_error <= refuse_code;
                    end else begin
                        normal_go <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take && exc_code != `MBG_EXC_NONE)
                    state_next = ST_SEND;
            end
            ST_SEND: begin
                if (tx_valid && tx_ready && idx_reg == 3'h2)
                    state_next = ST_CRC;
            end
            ST_CRC: begin
                if (tx_valid && tx_ready && tx_last)
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // byte that follows the one now on offer
    always @* begin
        case (idx_reg)
            `MBG_POS_SLAVE: byte_sel = func_reg;
            `MBG_POS_FUNC: byte_sel = code_reg;
            `MBG_POS_CODE: byte_sel = crc_next_lo(crc, tx_data);
            `MBG_POS_CRC_LO: byte_sel = crc[15:8];
            default: byte_sel = slave_reg;
        endcase
    end

    // crc folds each header byte as it leaves
    // the slave, function and code bytes; the crc bytes are not folded
    assign crc_step = tx_valid && tx_ready && (idx_reg < 3'h3);

    mbg_crc16 u_crc (
        .clock(clock),
        .rst(rst),
        .init(state_reg == ST_IDLE),
        .enable(crc_step),
        .data(tx_data),
        .crc(crc)
    );

    // output stage, index advance on handshake
    // a byte stays on tx_data until the transmitter takes it; the crc
    // module clears itself whenever the sequencer rests in idle
    always @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            idx_reg <= 3'h0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE) begin
                idx_reg <= 3'h0;
                tx_valid <= 1'b0;
                tx_last <= 1'b0;
                if (state_next == ST_SEND) begin
                    tx_valid <= 1'b1;
                    tx_data <= req_slave;
                end
            end else if (tx_valid && tx_ready) begin
                if (tx_last) begin
                    tx_valid <= 1'b0;
                    tx_last <= 1'b0;
                    idx_reg <= 3'h0;
                end else begin
                    idx_reg <= idx_reg + 3'h1;
                    tx_valid <= 1'b1;
                    tx_last <= (idx_reg + 3'h1 == `MBG_FRAME_BYTES - 3'h1);
                    tx_data <= byte_sel;
                end
            end else begin
                tx_data <= (idx_reg == 3'h0) ? slave_reg : tx_data;
            end
        end
    end

    // slave idles silently after bad frames; master timeout covers it
    // nothing here waits on the master, so a lost reply cannot stall
    // the guard: the next intact request is taken as usual

endmodule // mbg_guard

`default_nettype wire

// *** sim/mbg_guard_chk.sv ***
// mbg_guard_chk.sv - port checker for the request guard
// assumes: bound to mbg_guard, one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module mbg_guard_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_comm_error,
    input wire logic req_write,
    input wire logic req_intrusive,
    input wire logic write_lock,
    input wire logic normal_go,
    input wire logic cmd_refused,
    input wire logic [7:0] cmd_error,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready
);
    // ------------------------------------------------------------
    // frame byte position
    // ------------------------------------------------------------
    logic [2:0] pos_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // counts accepted bytes within one frame
    always @(posedge clock) begin
        if (rst)
            pos_reg <= 3'h0;
        else if (tx_valid && tx_ready)
            pos_reg <= tx_last ? 3'h0 : pos_reg + 3'h1;
    end
    a_quiet_error: assert property (req_valid && req_comm_error && !tx_valid |=>
        !tx_valid && !normal_go && !cmd_refused) else $error("reply to bad request");
    a_reply_cause: assert property (normal_go |-> $past(req_valid) &&
        !$past(req_comm_error) && !tx_valid) else $error("reply without request");
    a_slave_range: assert property (tx_valid && pos_reg == 3'h0 |->
        tx_data inside {[8'h01:8'hF7]}) else $error("slave byte out of range");
    a_func_flag: assert property (tx_valid && pos_reg == 3'h1 |-> tx_data[7])
        else $error("function flag clear");
    a_code_set: assert property (tx_valid && pos_reg == 3'h2 |->
        tx_data inside {[8'h01:8'h08], 8'h0A, 8'h0B}) else $error("bad code byte");
    a_five_bytes: assert property (tx_valid && tx_last |-> pos_reg == 3'h4)
        else $error("frame length wrong");
    a_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid &&
        $stable(tx_data) && $stable(tx_last)) else $error("byte dropped early");
    a_lock_wins: assert property (cmd_refused &&
        $past(write_lock && req_write && req_intrusive) |-> cmd_error == 8'h02)
        else $error("lock not reported");
endmodule // mbg_guard_chk
bind mbg_guard mbg_guard_chk u_chk (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req_comm_error(req_comm_error), .req_write(req_write), .req_intrusive(req_intrusive),
    .write_lock(write_lock), .normal_go(normal_go), .cmd_refused(cmd_refused),
    .cmd_error(cmd_error), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));
`default_nettype wire

// *** sim/mbg_line_model.sv ***
// mbg_line_model.sv - line transmitter taking frame bytes
// assumes: same clock as the guard; slow selects random stalls
`timescale 1ns/1ns
`default_nettype none
module mbg_line_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic slow,
    output logic tx_ready
);
    integer s = 9;
    // ready every cycle, or about one cycle in three
    always @(posedge clock) begin
        tx_ready <= !rst && (!slow || $unsigned($random(s)) % 3 == 0);
    end
endmodule // mbg_line_model
`default_nettype wire

// *** sim/mbg_guard_tb.sv ***
// mbg_guard_tb.sv - self-checking bench for the request guard
// assumes: core/ on the include path
`timescale 1ns/1ns
`default_nettype none
`include "mbg_consts.vh"
module mbg_guard_tb;
    reg clock = 0, rst = 1, rv = 0, cerr = 0, lock = 0, intr = 0, wr = 1, st = 1;
    reg pl = 0, slow = 0;
    reg [7:0] slv = 1, fn = 1;
    reg [10:0] bad = 0;
    reg [3:0] mask = 0;
    reg [1:0] pi = 0;
    reg [31:0] pwd = 0, pv = 0;
    wire go, rf, txv, txl, txr;
    wire [7:0] err, txd;
    integer seed = 9, n_fail = 0, comparisons = 0, i, k;
    reg [31:0] pw [0:3];
    reg [7:0] cd [0:10];
    reg [7:0] q [$];
    reg [7:0] ex [$];
    mbg_guard u_dut (.clock(clock), .rst(rst), .req_valid(rv), .req_slave(slv),
        .req_func(fn), .req_comm_error(cerr), .req_func_ok(!bad[3]),
        .req_state_ok(!bad[4]), .req_addr_ok(!bad[5]), .req_value_ok(!bad[6]),
        .req_dev_fail(bad[8]), .req_long(bad[10]), .req_prog_fail(bad[9]),
        .req_parity_err(bad[7]), .req_gw_path(bad[1]), .req_gw_target(bad[0]),
        .req_intrusive(intr), .req_write(wr), .req_struct_ok(st),
        .req_profile_mask(mask), .req_password(pwd), .write_lock(lock), .pw_load(pl),
        .pw_index(pi), .pw_value(pv), .busy_in(bad[2]), .normal_go(go),
        .cmd_refused(rf), .cmd_error(err), .tx_valid(txv), .tx_data(txd),
        .tx_last(txl), .tx_ready(txr));
    mbg_line_model u_line (.clock(clock), .rst(rst), .slow(slow), .tx_ready(txr));
    // free running clock
    initial begin
        forever #20 clock = ~clock;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task check(input [63:0] nm, input [31:0] e, input [31:0] s);
        comparisons++;
        if (e !== s) begin
            n_fail++;
            $display("unexpected %0s expected %0h seen %0h", nm, e, s);
        end
    endtask
    function [15:0] upd(input [15:0] c, input [7:0] d);
        integer n;
        c = c ^ d;
        for (n = 0; n < 8; n++) c = c[0] ? (c >> 1) ^ `MBG_CRC_POLY : c >> 1;
        return c;
    endfunction
    task end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one request, then watch the outputs for a bounded time
    task run;
        reg [7:0] c, re, se;
        reg [15:0] crc;
        integer j, b, sg, sr, ok;
        repeat (3) @(posedge clock); // lock needs two clocks to reach the guard
        rv <= 1;
        c = 0;
        for (b = 10; b >= 0; b--) if (bad[b]) c = cd[b];
        ok = 0;
        for (b = 0; b < 4; b++) if (mask[b] && pw[b] === pwd) ok = 1;
        ex.delete();
        q.delete();
        re = 0;
        sg = 0;
        sr = 0;
        se = 0;
        if (!cerr && slv != 0 && slv <= `MBG_SLAVE_MAX) begin
            if (c != 0) begin
                ex = '{slv, fn + `MBG_EXC_FLAG, c};
                crc = `MBG_CRC_INIT;
                foreach (ex[j]) crc = upd(crc, ex[j]);
                ex.push_back(crc[7:0]);
                ex.push_back(crc[15:8]);
            end else if (intr && wr && lock) re = 2;
            else if (intr && !st) re = 3;
            else if (intr && !ok) re = 1;
        end
        for (j = 0; j < 100; j++) begin
            @(posedge clock);
            if (j == 0) rv <= 0;
            sg += go;
            sr += rf;
            if (rf) se = err;
            if (txv && txr) q.push_back(txd);
            if (txv && txr && txl) break;
        end
        if (re == 0) check("go", ex.size() == 0 && c == 0 && !cerr && slv != 0 &&
            slv <= `MBG_SLAVE_MAX, sg);
        check("refused", re != 0, sr);
        if (re != 0) check("error", re, se);
        check("length", ex.size(), q.size());
        foreach (ex[j]) if (j < q.size()) check("byte", ex[j], q[j]);
        if (q.size() < ex.size())
            end_of_test;
        else
            $display("test done, comparisons %0d", comparisons);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        pw = '{`MBG_PW_ADMIN, `MBG_PW_SERVICES, `MBG_PW_ENGINEER, `MBG_PW_OPERATOR};
        cd = '{8'h0B, 8'h0A, 8'h06, 8'h01, 8'h01, 8'h02, 8'h03, 8'h08, 8'h04, 8'h07, 8'h05};
        repeat (2) @(posedge clock);
        rst <= 0;
        for (i = 0; i < 8; i++) begin
            intr <= 1;
            mask <= 4'h1 << (i / 2);
            pwd <= pw[(i / 2 + i % 2) % 4];
            run;
        end
        lock <= 1;
        pwd <= pw[3];
        run;
        lock <= 0;
        bad <= 11'h004;
        run;
        bad <= 0;
        run;
        for (i = 0; i < 60; i++) begin
            k = $random(seed);
            slv <= (i % 10 == 0) ? 8'h00 : (i % 10 == 5) ? 8'hF8 : 8'h01 + k[7:0] % 247;
            fn <= {1'b0, k[14:8]} % 8'h7F + 8'h01;
            wr <= k[15];
            cerr <= (i % 7 == 3);
            bad <= (i % 3 == 0) ? 11'h0 : (i % 3 == 1) ? k[26:16] : 11'h1 << (i % 11);
            intr <= k[27];
            lock <= k[28];
            st <= k[29];
            mask <= $random(seed);
            pwd <= pw[k[31:30]];
            slow <= i[0];
            if (i % 15 == 14) begin
                pl <= 1;
                pi <= k[1:0];
                pv <= k;
                pw[k[1:0]] = k;
                @(posedge clock);
                pl <= 0;
            end
            run;
        end
        end_of_test;
    end
endmodule // mbg_guard_tb
`default_nettype wire
